// [rtl/jfpr_top.sv]
`timescale 1ns/10ps
`include "jfpr_cfg.svh"
module jfpr_top import jfpr_pkg::*; #(
   parameter int CNT_W     = 21,
   parameter int SHORT_CYC = `JFPR_TO_SHORT_CYC,
   parameter int LONG_CYC  = `JFPR_TO_LONG_CYC,
   parameter int PAGE_BITS = `JFPR_FILL_BITS
) (
   input  wire logic                    clk,            // core clock, 20 mhz
   input  wire logic                    nrst,           // power-on reset, async, active low
   input  wire logic                    tck,            // link clock from the tap
   input  wire logic [`JFPR_IR_W-1:0]   irCode,         // current instruction code
   input  wire logic                    captureDr,      // tap in capture-dr
   input  wire logic                    shiftDr,        // tap in shift-dr
   input  wire logic                    updateDr,       // tap in update-dr
   input  wire logic                    runIdle,        // tap in run-test/idle
   input  wire logic                    tdi,            // serial data in
   output logic                         tdo,            // serial data out
   output logic                         drSelected,     // one of our registers is in the path
   input  wire logic                    extRstN,        // external reset pin, active low
   input  wire jfpr_tosel_t             clkFuse,        // clock option fuses
   output logic                         coreRstN,       // reset to the core, active low
   output logic                         progEnabled,    // key accepted (tck domain)
   output logic [`JFPR_CMD_W-1:0]       cmdWord,        // command for the flash (clk domain)
   output logic                         cmdExec,        // one-cycle execute strobe (clk domain)
   input  wire logic [`JFPR_CMD_W-1:0]  cmdResult,      // result from the flash (clk domain)
   input  wire logic                    cmdResultValid, // result strobe (clk domain)
   output logic                         pageWrEn,       // page buffer byte write (tck domain)
   output logic [$clog2(PAGE_BITS/`JFPR_BYTE_W)-1:0] pageWrAddr, // byte index in the page
   output logic [`JFPR_BYTE_W-1:0]      pageWrData,     // byte to write
   output logic [$clog2(PAGE_BITS/`JFPR_BYTE_W)-1:0] pageRdAddr, // byte index to fetch
   input  wire logic [`JFPR_BYTE_W-1:0] pageRdData      // fetched byte, combinational
);

   // byte index width of one page
   localparam int AW = $clog2(PAGE_BITS / `JFPR_BYTE_W);

   if (PAGE_BITS % `JFPR_BYTE_W != 0 || PAGE_BITS < 2 * `JFPR_BYTE_W) begin : g_bad
      $error("jfpr_top: page size must be a whole number of bytes, two at least");
   end

   // the counter width must keep its power of two inside an int
   if (CNT_W < 1 || CNT_W > 30) begin : g_bad_cnt
      $error("jfpr_top: time-out counter width out of range");
   end

   // tck domain: hold, key and command chains
   logic                    holdBit_q;
   logic [`JFPR_KEY_W-1:0]  key_q;
   logic                    progEn_q;
   logic [`JFPR_CMD_W-1:0]  cmdShift_q;
   logic [`JFPR_CMD_W-1:0]  cmdApplied_q;

   // execute request out, result back in (result hold is written on the core side)
   logic                    runIdlePrev_q;
   logic                    execTgl_q;
   logic [`JFPR_CMD_W-1:0]  resultTck_q;
   logic                    resultSeen_q;
   logic                    resultTglSync;
   logic [`JFPR_CMD_W-1:0]  resultHold_q;

   // page chains: bit and byte counters, shifter, write port
   logic [2:0]              pgBit_q;
   logic [AW-1:0]           pgAddr_q;
   logic [`JFPR_BYTE_W-1:0] pgShift_q;
   logic                    pgWrEn_q;
   logic [AW-1:0]           pgWrAddr_q;
   logic [`JFPR_BYTE_W-1:0] pgWrData_q;

   // instruction decode on the 4-bit code
   wire selHold   = (irCode == IR_HOLD);
   wire selUnlock = (irCode == IR_UNLOCK);
   wire selCmd    = (irCode == IR_CMD);
   wire selFill   = (irCode == IR_FILL);
   wire selDump   = (irCode == IR_DUMP);

   // gating and edge helpers
   wire pageOn    = progEn_q && (selFill || selDump);
   wire byteDone  = (pgBit_q == 3'h7);
   wire idleEntry = runIdle && !runIdlePrev_q;
   wire resultNew = resultTglSync ^ resultSeen_q;

   // hold bit: single stage, shift is its only action; the tap itself is never reset here
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) holdBit_q <= 1'b0;
      else if (shiftDr && selHold) holdBit_q <= tdi;
   end

   // key register shifts lsb first and clears on power-on
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) key_q <= `JFPR_KEY_RST;
      else if (shiftDr && selUnlock) key_q <= {tdi, key_q[`JFPR_KEY_W-1:1]};
   end

   // every key update re-judges the key, so a cleared key locks programming again
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) progEn_q <= 1'b0;
      else if (updateDr && selUnlock) progEn_q <= (key_q == `JFPR_KEY_VALUE);
   end

   // command chain: capture old result, shift lsb first
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) cmdShift_q <= '0;
      else if (captureDr && selCmd) cmdShift_q <= resultTck_q;
      else if (shiftDr && selCmd) cmdShift_q <= {tdi, cmdShift_q[`JFPR_CMD_W-1:1]};
   end

   // command applied on update only while unlocked
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) cmdApplied_q <= '0;
      else if (updateDr && selCmd && progEn_q) cmdApplied_q <= cmdShift_q;
   end

   // entry to run-test/idle asks the core side for one execute cycle
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         runIdlePrev_q <= 1'b0;
         execTgl_q     <= 1'b0;
      end else begin
         runIdlePrev_q <= runIdle;
         if (idleEntry && selCmd && progEn_q) execTgl_q <= ~execTgl_q;
      end
   end

   // result word: held steady on the core side before its toggle, so sampling here is safe
   // tck runs only inside frames, so the programmer idles a few edges before capturing
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         resultSeen_q <= 1'b0;
         resultTck_q  <= '0;
      end else begin
         resultSeen_q <= resultTglSync;
         if (resultNew) resultTck_q <= resultHold_q;
      end
   end

   // page chains count bits from capture; capture itself moves no data
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         pgBit_q  <= 3'h0;
         pgAddr_q <= '0;
      end else if (captureDr && pageOn) begin
         pgBit_q  <= 3'h0;
         pgAddr_q <= '0;
      end else if (shiftDr && pageOn) begin
         pgBit_q <= pgBit_q + 3'h1;
         if (byteDone) pgAddr_q <= pgAddr_q + AW'(1);
      end
   end

   // 8-bit shifter behind both virtual chains; dump ignores tdi and starts one byte late
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) pgShift_q <= '0;
      else if (shiftDr && pageOn && selDump && byteDone) pgShift_q <= pageRdData;
      else if (shiftDr && pageOn && selDump) pgShift_q <= {1'b0, pgShift_q[`JFPR_BYTE_W-1:1]};
      else if (shiftDr && pageOn) pgShift_q <= {tdi, pgShift_q[`JFPR_BYTE_W-1:1]};
   end

   // each finished fill byte goes straight to the page buffer; update-dr writes nothing
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         pgWrEn_q   <= 1'b0;
         pgWrAddr_q <= '0;
         pgWrData_q <= '0;
      end else begin
         pgWrEn_q <= shiftDr && pageOn && selFill && byteDone;
         if (shiftDr && pageOn && selFill && byteDone) begin
            pgWrAddr_q <= pgAddr_q;
            pgWrData_q <= {tdi, pgShift_q[`JFPR_BYTE_W-1:1]};
         end
      end
   end

   // tdo picks the stage zero of the chain in the path
   assign tdo = selHold   ? holdBit_q :
                selUnlock ? key_q[0] :
                selCmd    ? cmdShift_q[0] :
                (selFill || selDump) ? pgShift_q[0] : 1'b0;

   // page port and progEnabled straight from flops; drSelected decoded from irCode
   assign drSelected  = selHold || selUnlock || selCmd || selFill || selDump;
   assign progEnabled = progEn_q;
   assign pageWrEn    = pgWrEn_q;
   assign pageWrAddr  = pgWrAddr_q;
   assign pageWrData  = pgWrData_q;
   assign pageRdAddr  = pgAddr_q;

   // clk domain: synchronised levels from the pin and from tck
   logic                   extRstNSync;
   logic                   holdSync;
   logic                   execTglSync;

   // execute strobe, command copy and result toggle
   logic                   execSeen_q;
   logic [`JFPR_CMD_W-1:0] cmdWord_q;
   logic                   cmdExec_q;
   logic                   resultTgl_q;

   // pin held low during reset so the core starts out in reset
   jfpr_sync3 #(.RST_VAL(1'b0)) u_pinSync (
      .clk   (clk),
      .nrst  (nrst),
      .async (extRstN),
      .level (extRstNSync)
   );

   // hold bit is a level: no latch stage, only the synchroniser
   jfpr_sync3 #(.RST_VAL(1'b0)) u_holdSync (
      .clk   (clk),
      .nrst  (nrst),
      .async (holdBit_q),
      .level (holdSync)
   );

   // execute toggle into the core clock
   jfpr_sync3 #(.RST_VAL(1'b0)) u_execSync (
      .clk   (clk),
      .nrst  (nrst),
      .async (execTgl_q),
      .level (execTglSync)
   );

   // result toggle back to tck; it only moves while tck runs
   jfpr_sync3 #(.RST_VAL(1'b0)) u_resultSync (
      .clk   (tck),
      .nrst  (nrst),
      .async (resultTgl_q),
      .level (resultTglSync)
   );

   // hold bit counts exactly like the pin going low
   wire resetReq = !extRstNSync || holdSync;
   wire execNew  = execTglSync ^ execSeen_q;

   jfpr_rst_timeout #(
      .CNT_W     (CNT_W),
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC)
   ) u_timeout (
      .clk      (clk),
      .nrst     (nrst),
      .resetReq (resetReq),
      .toSel    (clkFuse),
      .coreRstN (coreRstN)
   );

   // applied command is stable once its toggle has settled, so it is copied then
   // executes closer than six core cycles apart could copy a word still changing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         execSeen_q <= 1'b0;
         cmdExec_q  <= 1'b0;
         cmdWord_q  <= '0;
      end else begin
         execSeen_q <= execTglSync;
         cmdExec_q  <= execNew;
         if (execNew) cmdWord_q <= cmdApplied_q;
      end
   end

   // result kept steady here, announced to tck by a toggle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         resultHold_q <= '0;
         resultTgl_q  <= 1'b0;
      end else if (cmdResultValid) begin
         resultHold_q <= cmdResult;
         resultTgl_q  <= ~resultTgl_q;
      end
   end

   // registered command outputs of the core side
   assign cmdWord = cmdWord_q;
   assign cmdExec = cmdExec_q;

   // tck side: chains, gating and page transfers
   a_hold_shift: assert property (@(posedge tck) disable iff (!nrst)
      shiftDr && selHold |=> holdBit_q == $past(tdi))
      else $error("hold bit did not take tdi in shift-dr");

   a_key_shift: assert property (@(posedge tck) disable iff (!nrst)
      shiftDr && selUnlock |=> key_q == {$past(tdi), $past(key_q[`JFPR_KEY_W-1:1])})
      else $error("key register did not shift lsb first");

   a_unlock_match: assert property (@(posedge tck) disable iff (!nrst)
      updateDr && selUnlock |=> progEn_q == ($past(key_q) == `JFPR_KEY_VALUE))
      else $error("programming enable does not follow the key compare");

   a_cmd_capture: assert property (@(posedge tck) disable iff (!nrst)
      captureDr && selCmd |=> cmdShift_q == $past(resultTck_q))
      else $error("capture-dr did not load the previous result");

   a_cmd_update: assert property (@(posedge tck) disable iff (!nrst)
      updateDr && selCmd && progEn_q |=> cmdApplied_q == $past(cmdShift_q))
      else $error("update-dr did not apply the shifted command");

   a_exec_toggle: assert property (@(posedge tck) disable iff (!nrst)
      idleEntry && selCmd && progEn_q |=> execTgl_q != $past(execTgl_q))
      else $error("run-test/idle entry did not ask for an execute cycle");

   a_cmd_locked: assert property (@(posedge tck) disable iff (!nrst)
      !progEn_q && !(updateDr && selUnlock)
      |=> $stable(cmdApplied_q) && $stable(execTgl_q) && !pgWrEn_q)
      else $error("locked device acted on a command or page byte");

   a_page_locked: assert property (@(posedge tck) disable iff (!nrst)
      shiftDr && !progEn_q |=> $stable(pgBit_q) && $stable(pgAddr_q) && $stable(pgShift_q))
      else $error("locked device moved the page chain");

   a_fill_write: assert property (@(posedge tck) disable iff (!nrst)
      shiftDr && selFill && progEn_q && byteDone
      |=> pgWrEn_q && pgWrData_q == {$past(tdi), $past(pgShift_q[`JFPR_BYTE_W-1:1])}
          && pgWrAddr_q == $past(pgAddr_q))
      else $error("completed fill byte not written to the page buffer");

   a_fill_gap: assert property (@(posedge tck) disable iff (!nrst)
      pgWrEn_q |=> !pgWrEn_q [*7])
      else $error("page byte written more than once per eight bits");

   a_dump_load: assert property (@(posedge tck) disable iff (!nrst)
      shiftDr && selDump && progEn_q && byteDone |=> pgShift_q == $past(pageRdData))
      else $error("dump shifter did not fetch the next page byte");

   a_dump_no_tdi: assert property (@(posedge tck) disable iff (!nrst)
      shiftDr && selDump && progEn_q && !byteDone |=> pgShift_q == {1'b0, $past(pgShift_q[`JFPR_BYTE_W-1:1])})
      else $error("dump shifter took tdi");

   // core side: execute strobe and reset hold
   a_exec_once: assert property (@(posedge clk) disable iff (!nrst)
      cmdExec_q |=> !cmdExec_q)
      else $error("execute strobe longer than one core cycle");

   a_exec_word: assert property (@(posedge clk) disable iff (!nrst)
      execNew |=> cmdExec_q && cmdWord_q == $past(cmdApplied_q))
      else $error("executed word differs from the applied command");

   a_hold_reset: assert property (@(posedge clk) disable iff (!nrst)
      holdSync |=> !coreRstN ##1 !coreRstN)
      else $error("core left reset while the hold bit was set");

   // main scenarios
   c_unlock: cover property (@(posedge tck) disable iff (!nrst) $rose(progEn_q));
   c_fill_byte: cover property (@(posedge tck) disable iff (!nrst) pgWrEn_q);
   c_dump_byte: cover property (@(posedge tck) disable iff (!nrst) shiftDr && selDump && progEn_q && byteDone);
   c_exec: cover property (@(posedge clk) disable iff (!nrst) cmdExec_q);
endmodule : jfpr_top

// [rtl/jfpr_cfg.svh]
`ifndef JFPR_CFG_SVH
`define JFPR_CFG_SVH
// How it works
// - code 4'hc selects the one-bit hold-in-reset register; the tap itself stays untouched
// - under hold-in-reset only shift-dr acts, shifting the bit on tck
// - a one in the hold bit acts exactly like the external reset pin pulled low
// - the hold bit drives reset unlatched, so reset follows the shifted bit at once; here it first crosses a three-flop synchroniser into clk
// - after the hold bit clears, reset stays on for a fuse-selected time-out
// - code 4'h4 selects a 16-bit key register, loaded serially in shift-dr
// - update-dr compares the key with 16'ha370; only an exact match enables programming
// - the key register clears to zero on power-on reset, programming disabled
// - code 4'h5 selects the 15-bit command register between tdi and tdo
// - capture-dr loads the command register with the previous command's result
// - shift-dr shifts the command register, old result out on tdo, new command in
// - update-dr applies the shifted command to the flash programming inputs
// - entering run-test/idle makes one internal clock that executes the applied command
// - code 4'h6 gives a 1024-bit page-fill chain built on an 8-bit shifter
// - page fill writes each finished byte to the page buffer in shift-dr; update-dr idle
// - code 4'h7 gives a 1032-bit page-dump chain built on an 8-bit shifter
// - page dump: capture-dr moves nothing; shift-dr fetches bytes, shifts them out, ignores tdi
// - the instruction code is 4 bits wide, sixteen codes at most
// - every shift register moves least significant bit first, in and out

`define JFPR_IR_W        4
`define JFPR_IR_HOLD     4'hc
`define JFPR_IR_UNLOCK   4'h4
`define JFPR_IR_CMD      4'h5
`define JFPR_IR_FILL     4'h6
`define JFPR_IR_DUMP     4'h7
`define JFPR_KEY_W       16
`define JFPR_KEY_VALUE   16'ha370
`define JFPR_KEY_RST     16'h0000
`define JFPR_CMD_W       15
`define JFPR_BYTE_W      8
`define JFPR_FILL_BITS   1024
`define JFPR_DUMP_BITS   1032
`define JFPR_CLK_MHZ     20
`define JFPR_TO_FAST_CYC 6
`define JFPR_TO_SHORT_US 4100
`define JFPR_TO_LONG_US  65000
`define JFPR_TO_SHORT_CYC (`JFPR_TO_SHORT_US * `JFPR_CLK_MHZ)
`define JFPR_TO_LONG_CYC  (`JFPR_TO_LONG_US * `JFPR_CLK_MHZ)
`define JFPR_TO_SEL_FAST  2'h0
`define JFPR_TO_SEL_SHORT 2'h1
`define JFPR_TO_SEL_LONG  2'h2
`endif

// [rtl/jfpr_pkg.sv]
`include "jfpr_cfg.svh"
package jfpr_pkg;
   // instruction codes this block answers to
   typedef enum logic [`JFPR_IR_W-1:0] {
      IR_UNLOCK = `JFPR_IR_UNLOCK,
      IR_CMD    = `JFPR_IR_CMD,
      IR_FILL   = `JFPR_IR_FILL,
      IR_DUMP   = `JFPR_IR_DUMP,
      IR_HOLD   = `JFPR_IR_HOLD
   } jfpr_instr_t;
   // reset time-out selection from the clock fuses
   typedef enum logic [1:0] {
      TO_FAST  = `JFPR_TO_SEL_FAST,
      TO_SHORT = `JFPR_TO_SEL_SHORT,
      TO_LONG  = `JFPR_TO_SEL_LONG
   } jfpr_tosel_t;
endpackage : jfpr_pkg

// [rtl/jfpr_sync3.sv]
`timescale 1ns/10ps
module jfpr_sync3 import jfpr_pkg::*; #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk,    // destination clock
   input  wire logic nrst,   // async reset, active low
   input  wire logic async,  // level from another domain
   output logic      level   // settled level
);
   logic f1_q;
   logic f2_q;
   logic f3_q;
   // the first stage feeds only the second; a change counts once stages two and three agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         f1_q  <= RST_VAL;
         f2_q  <= RST_VAL;
         f3_q  <= RST_VAL;
         level <= RST_VAL;
      end else begin
         f1_q <= async;
         f2_q <= f1_q;
         f3_q <= f2_q;
         if (f2_q == f3_q) level <= f3_q;
      end
   end
endmodule : jfpr_sync3

// [rtl/jfpr_rst_timeout.sv]
`timescale 1ns/10ps
`include "jfpr_cfg.svh"
module jfpr_rst_timeout import jfpr_pkg::*; #(
   parameter int CNT_W     = 21,
   parameter int SHORT_CYC = `JFPR_TO_SHORT_CYC,
   parameter int LONG_CYC  = `JFPR_TO_LONG_CYC
) (
   input  wire logic        clk,       // core clock
   input  wire logic        nrst,      // async reset, active low
   input  wire logic        resetReq,  // pin or hold bit asks for reset
   input  wire jfpr_tosel_t toSel,     // fuse time-out choice
   output logic             coreRstN   // core reset, active low
);
   logic [CNT_W-1:0] cnt_q;
   wire  [CNT_W-1:0] target;

   if (SHORT_CYC >= 2**CNT_W || LONG_CYC >= 2**CNT_W || SHORT_CYC < 1 || LONG_CYC < 1) begin : g_bad
      $error("jfpr_rst_timeout: time-out counts do not fit the counter");
   end

   // unused fuse code falls back to the longest wait, the safe side
   assign target = (toSel == TO_FAST)  ? CNT_W'(`JFPR_TO_FAST_CYC) :
                   (toSel == TO_SHORT) ? CNT_W'(SHORT_CYC) : CNT_W'(LONG_CYC);

   // reset held while requested, then counted out before release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q    <= '0;
         coreRstN <= 1'b0;
      end else if (resetReq) begin
         cnt_q    <= '0;
         coreRstN <= 1'b0;
      end else if (!coreRstN) begin
         cnt_q <= cnt_q + CNT_W'(1);
         if (cnt_q == target - CNT_W'(1)) coreRstN <= 1'b1;
      end
   end

   a_release_count: assert property (@(posedge clk) disable iff (!nrst)
      $rose(coreRstN) |-> $past(cnt_q) == $past(target) - CNT_W'(1) && !$past(resetReq))
      else $error("core reset released before the time-out ran out");
   a_req_holds: assert property (@(posedge clk) disable iff (!nrst)
      resetReq |=> !coreRstN)
      else $error("core reset not held while requested");
   c_timeout_done: cover property (@(posedge clk) disable iff (!nrst) $rose(coreRstN));
endmodule : jfpr_rst_timeout

// [test/jfpr_prog_model.sv]
`timescale 1ns/10ps
// programmer on the far side of the tap; it is the only device on the chain
// tck runs only inside frames, so the link clock stands still between them
module jfpr_prog_model (
   output logic       tck,       // link clock
   output logic [3:0] irCode,    // instruction held in the ir
   output logic       captureDr, // capture-dr level
   output logic       shiftDr,   // shift-dr level
   output logic       updateDr,  // update-dr level
   output logic       runIdle,   // run-test/idle level
   output logic       tdi,       // serial data to the device
   input  wire logic  tdo        // serial data from the device
);
   int stretch = 0; // extra low time per tck, lets the bench play a slow programmer
   initial begin
      {tck, irCode, captureDr, shiftDr, updateDr, runIdle, tdi} = '0;
   end
   // one tck period; levels only change just after the falling edge
   task automatic pulse();
      #(3 + stretch) tck = 1'b1;
      #3 tck = 1'b0;
   endtask : pulse
   // edges with no state level, as exit/select states and to let crossings settle
   task automatic idle(input int n);
      repeat (n) pulse();
   endtask : idle
   // one dr frame: capture, n shifts, optional update, one closing edge
   task automatic scan(input logic [3:0] ir, input logic [1039:0] din, input int n, input bit upd,
                       output logic [1039:0] dout);
      dout = '0;
      irCode = ir;
      captureDr = 1'b1;
      pulse();
      captureDr = 1'b0;
      shiftDr = 1'b1;
      for (int i = 0; i < n; i++) begin
         tdi = din[i];
         dout[i] = tdo;
         pulse();
      end
      shiftDr = 1'b0;
      updateDr = upd;
      pulse();
      updateDr = 1'b0;
      tdi = ~tdi; // released line shows the inverse, not the last bit
      pulse();
   endtask : scan
   // run-test/idle is only visited for commands that need the internal clock
   task automatic run_idle();
      runIdle = 1'b1;
      pulse();
      pulse();
      runIdle = 1'b0;
      pulse();
   endtask : run_idle
endmodule : jfpr_prog_model

// [test/jfpr_top_test.sv]
`timescale 1ns/10ps
`include "jfpr_cfg.svh"
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin errors++; $display("unexpected %0t: %s", $time, m); end end
module jfpr_top_test import jfpr_pkg::*; ;
   localparam int SHORT = 20; // shortened time-outs keep the run brief
   localparam int LONG  = 40;
   logic          clk = 1'b0, nrst = 1'b0, extRstN = 1'b1, cmdResultValid = 1'b0;
   logic          tck, captureDr, shiftDr, updateDr, runIdle, tdi, tdo, drSelected;
   logic          coreRstN, progEnabled, cmdExec, pageWrEn;
   logic [3:0]    irCode;
   jfpr_tosel_t   clkFuse = TO_FAST;
   logic [14:0]   cmdWord, cmd, res, cmdResult = 15'h0000;
   logic [15:0]   key;
   logic [6:0]    pageWrAddr, pageRdAddr;
   logic [7:0]    pageWrData, pageRdData;
   logic [1039:0] din, dout;
   logic [14:0]   cmdQ[$];
   logic [14:0]   pageQ[$];
   int            errors = 0, total_checks = 0, cycles = 0, cnt;
   int            toCyc[4] = '{`JFPR_TO_FAST_CYC, SHORT, LONG, LONG}; // unused code 3 waits long
   jfpr_top #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut_u (
      .clk(clk), .nrst(nrst), .tck(tck), .irCode(irCode), .captureDr(captureDr), .shiftDr(shiftDr),
      .updateDr(updateDr), .runIdle(runIdle), .tdi(tdi), .tdo(tdo), .drSelected(drSelected), .extRstN(extRstN),
      .clkFuse(clkFuse), .coreRstN(coreRstN), .progEnabled(progEnabled), .cmdWord(cmdWord), .cmdExec(cmdExec),
      .cmdResult(cmdResult), .cmdResultValid(cmdResultValid), .pageWrEn(pageWrEn), .pageWrAddr(pageWrAddr),
      .pageWrData(pageWrData), .pageRdAddr(pageRdAddr), .pageRdData(pageRdData));
   jfpr_prog_model prog_u (.tck(tck), .irCode(irCode), .captureDr(captureDr), .shiftDr(shiftDr),
      .updateDr(updateDr), .runIdle(runIdle), .tdi(tdi), .tdo(tdo));
   // page buffer stand-in, answers at once as the dump path needs
   assign pageRdData = {1'b0, pageRdAddr} ^ 8'ha5;
   always #25 clk = ~clk;
   // hang guard, far above the fewer than a thousand cycles the tests take
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end
   // exec watcher: each pulse must match the oldest applied command, one pulse each
   always @(posedge clk) if (cmdExec === 1'b1) begin
      if (cmdQ.size() == 0) `CHK(1'b1, 1'b0, "exec without a command")
      else `CHK(cmdWord, cmdQ.pop_front(), "executed command")
   end
   // page writer watcher, tck side
   always @(posedge tck) if (pageWrEn === 1'b1) begin
      if (pageQ.size() == 0) `CHK(1'b1, 1'b0, "page write not expected")
      else `CHK({pageWrAddr, pageWrData}, pageQ.pop_front(), "page byte")
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : wait_clk
   task automatic hold(input logic b);
      prog_u.scan(4'hc, {1039'h0, b}, 1, 1'b0, dout);
   endtask : hold
   task automatic rand_din();
      din = '0;
      for (int i = 0; i < 32; i++) din[i*32 +: 32] = $urandom;
   endtask : rand_din
   // command frame plus execute; locked parts must stay quiet, so nothing is queued then
   task automatic send_cmd(input bit expect_exec);
      cmd = 15'($urandom);
      prog_u.scan(4'h5, {1025'h0, cmd}, 15, 1'b1, dout);
      if (expect_exec) cmdQ.push_back(cmd);
      prog_u.run_idle();
      wait_clk(12);
   endtask : send_cmd
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   initial begin
      void'($urandom(96));
      wait_clk(5);
      nrst = 1'b1;
      `CHK(progEnabled, 1'b0, "key clear after power-on")
      // hold bit then release, once per fuse time-out choice
      foreach (toCyc[f]) begin
         wait_clk(2);
         clkFuse = jfpr_tosel_t'(f[1:0]);
         hold(1'b1);
         wait_clk(8);
         `CHK(coreRstN, 1'b0, "hold bit resets core")
         hold(1'b0);
         cnt = 0;
         while (coreRstN !== 1'b1 && cnt < 200) begin
            wait_clk(1);
            cnt++;
         end
         `CHK(cnt >= toCyc[f] && cnt <= toCyc[f] + 8, 1'b1, "time-out length")
      end
      wait_clk(2);
      extRstN = 1'b0;
      wait_clk(6);
      `CHK(coreRstN, 1'b0, "pin reset")
      extRstN = 1'b1;
      wait_clk(60);
      $display("test reset done");
      hold(1'b1);
      key = 16'($urandom);
      if (key == `JFPR_KEY_VALUE) key ^= 16'h0001;
      prog_u.scan(4'h4, {1024'h0, key}, 16, 1'b1, dout);
      `CHK(progEnabled, 1'b0, "wrong key refused")
      send_cmd(1'b0);
      rand_din();
      prog_u.scan(4'h6, din, 1024, 1'b1, dout);
      prog_u.scan(4'h4, {1024'h0, `JFPR_KEY_VALUE}, 16, 1'b1, dout);
      `CHK(progEnabled, 1'b1, "key accepted")
      $display("test unlock done");
      // prompt then slow programmer, each command with a result read back
      for (int k = 0; k < 2; k++) begin
         prog_u.stretch = k * 20;
         send_cmd(1'b1);
         res = 15'($urandom);
         cmdResult = res;
         cmdResultValid = 1'b1;
         wait_clk(1);
         cmdResultValid = 1'b0;
         prog_u.idle(8);
         prog_u.scan(4'h5, din, 15, 1'b0, dout);
         `CHK(dout[14:0], res, "captured result")
      end
      prog_u.stretch = 0;
      $display("test command done");
      rand_din();
      for (int b = 0; b < 128; b++) pageQ.push_back({7'(b), din[b*8 +: 8]});
      prog_u.scan(4'h6, din, 1024, 1'b1, dout);
      prog_u.idle(2);
      `CHK(pageQ.size(), 0, "all page bytes written")
      rand_din();
      prog_u.scan(4'h7, din, 1032, 1'b0, dout);
      for (int b = 0; b < 128; b++) `CHK(dout[8 + b*8 +: 8], {1'b0, 7'(b)} ^ 8'ha5, "dumped byte")
      $display("test page done");
      prog_u.scan(4'h4, 1040'h0, 16, 1'b1, dout);
      `CHK(progEnabled, 1'b0, "cleared key locks")
      send_cmd(1'b0);
      hold(1'b0);
      for (int c = 0; c < 16; c++) begin
         prog_u.irCode = 4'(c);
         #1 `CHK(drSelected, c inside {4, 5, 6, 7, 12}, "code decode")
      end
      $display("test relock and decode done");
      end_sim();
   end
endmodule : jfpr_top_test
